/* File: tdps_consts.svh */
// Purpose: constants for the timer data port sequencer
// Assumes: included by bare name
// Notes:   pointer = {group[2:0], element[1:0]} plus a byte pointer
`ifndef TDPS_CONSTS_SVH
`define TDPS_CONSTS_SVH
`define TDPS_GRP_CONTROL      3'h7
`define TDPS_GRP_FIRST        3'h1
`define TDPS_GRP_LAST         3'h5
`define TDPS_ELEM_MODE        2'h0
`define TDPS_ELEM_RELOAD      2'h1
`define TDPS_ELEM_CAPTURE     2'h2
`define TDPS_ELEM_HOLDCYC     2'h3
`define TDPS_CTL_ALARM1       2'h0
`define TDPS_CTL_GLOBAL       2'h1
`define TDPS_CTL_ALARM2       2'h2
`define TDPS_GC_CMP1_BIT      2
`define TDPS_GC_CMP2_BIT      3
`define TDPS_GC_FOUT_GATE_BIT 12
`define TDPS_GC_BUS_WIDTH_BIT 13
`define TDPS_GC_SEQ_DIS_BIT   14
`define TDPS_GC_RESET         16'h0000
`define TDPS_CMD_LOAD_PTR     3'h0
`define TDPS_CMD_SET_BIT      3'h1
`define TDPS_CMD_CLR_BIT      3'h2
`define TDPS_CMD_CAPTURE      3'h3
`define TDPS_OC_LOW_GND       3'h0
`define TDPS_OC_TC_HIGH       3'h1
`define TDPS_OC_TC_TOGGLE     3'h2
`define TDPS_OC_HIGH_Z        3'h4
`define TDPS_OC_TC_LOW        3'h5
`endif

/* File: tdps_pkg.sv */
// Purpose: types for the timer data port sequencer
// Assumes: nothing
// Notes:   none
package tdps_pkg;
  typedef enum logic [1:0] {
    TDPS_CYC_ELEMENT = 2'b00,
    TDPS_CYC_HOLD    = 2'b01,
    TDPS_CYC_CONTROL = 2'b11,
    TDPS_CYC_STATUS  = 2'b10
  } tdps_cycle_t;
endpackage

/* File: tdps_out_logic.sv */
// Purpose: output polarity and comparator substitution for one counter
// Assumes: terminal count level from the counter core
// Notes:   result is the level before the pin buffer
`timescale 1ns/10ps
`default_nettype none
`include "tdps_consts.svh"
module tdps_out_logic (
  // controls
  input  wire logic [2:0] output_control_field,
  input  wire logic       cmp_enable,
  // sources
  input  wire logic       terminal_count,
  input  wire logic       cmp_match,
  // result
  output logic            out_level
);
  logic output_polarity_bit;
  assign output_polarity_bit = output_control_field[2];
  always_comb begin
    if (cmp_enable) begin
      // high-z option shows active high, grounded shows active low [R14] [R19]
      if (output_control_field == `TDPS_OC_HIGH_Z) begin
        out_level = cmp_match;
      end else if (output_control_field == `TDPS_OC_LOW_GND) begin
        out_level = ~cmp_match;
      end else begin
        out_level = output_polarity_bit ? ~cmp_match : cmp_match;
      end
    end else begin
      // grounded option active high tc, high-z active low tc [R13]
      if (output_control_field == `TDPS_OC_LOW_GND) begin
        out_level = terminal_count;
      end else if (output_control_field == `TDPS_OC_HIGH_Z) begin
        out_level = ~terminal_count;
      end else begin
        out_level = output_polarity_bit ? ~terminal_count : terminal_count;
      end
    end
  end
endmodule // tdps_out_logic
`default_nettype wire

/* File: tdps_sequencer.sv */
// Purpose: data pointer, prefetch latch and register file of a five counter timer
// Assumes: one-cycle strobes from host logic on sys_clk; counter core outside
// Notes:   commands are {op[2:0], arg[4:0]} on cmd_data
// What this block does
// R1: element steps 00,01,10 then group increments
// R2: element never reaches 11; group wraps 1..5
// R3: element 11 steps group only, captures
// R4: control group steps element, group fixed
// R5: control group element 11: status, no step
// R6: control port read always returns status
// R7: byte bus toggles byte pointer each transfer
// R8: pointer updates then prefetch latch refills
// R9: refill also after writes and pointer load
// R10: host reloads pointer after other commands
// R11: host reloads pointer after gate capture
// R12: status shows byte pointer and outputs
// R13: tc polarity follows output control field
// R14: comparator polarity per polarity bit, option
// R15: five groups: reload, capture, mode registers
// R16: terminal count reloads from reload/capture
// R17: capture copies counter without disturbing it
// R18: comparator true while count equals alarm
// R19: comparator polarity by output control field
// R20: gate, width, sequencing bits by command
// R21: capture register usable as reload source
// R22: host may zero reload to accumulate
// R23: width bit: byte pairs or full words
// R24: sequencing disable bit freezes pointer
// R25: group codes 1..5 map counters 1..5
`timescale 1ns/10ps
`default_nettype none
`include "tdps_consts.svh"
module tdps_sequencer
  import tdps_pkg::*;
#(
  parameter int NUM_CNT = 5
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // host strobes
  input  wire logic                    cmd_wr,
  input  wire logic [7:0]              cmd_data,
  input  wire logic                    data_wr,
  input  wire logic                    data_rd,
  input  wire logic [15:0]             data_in,
  input  wire logic                    ctrl_rd,
  // read data
  output logic      [15:0]             rd_data,
  // counter core
  input  wire logic [NUM_CNT*16-1:0]   counter_value,
  input  wire logic [NUM_CNT-1:0]      terminal_count,
  output logic      [NUM_CNT-1:0]      reload_from_capture,
  output logic      [NUM_CNT*16-1:0]   reload_word,
  output logic      [NUM_CNT-1:0]      sw_capture,
  input  wire logic [NUM_CNT-1:0]      hw_capture,
  // pins
  output logic      [NUM_CNT-1:0]      out_level,
  output logic                         freq_out_gate_bit
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [2:0]  group_ptr, next_group_ptr;
  logic [1:0]  element_ptr, next_element_ptr;
  logic        byte_ptr, next_byte_ptr;
  logic [15:0] prefetch, next_prefetch;
  logic        refill, next_refill;
  logic [15:0] global_config, next_global_config;
  logic [15:0] reload_value [NUM_CNT];
  logic [15:0] capture_value [NUM_CNT];
  logic [15:0] counter_config [NUM_CNT];
  logic [15:0] alarm_compare_value [2];
  logic [15:0] wr_word, next_wr_word;
  logic [7:0]  count_status;
  logic [15:0] addressed;
  logic [NUM_CNT-1:0] alt_src, next_alt_src;
  logic        bus_width_bit;
  logic        sequencing_disable_bit;
  tdps_cycle_t cycle;
  logic        xfer, word_done, cmd_load;
  assign bus_width_bit          = global_config[`TDPS_GC_BUS_WIDTH_BIT];
  assign sequencing_disable_bit = global_config[`TDPS_GC_SEQ_DIS_BIT];
  assign freq_out_gate_bit      = global_config[`TDPS_GC_FOUT_GATE_BIT];
  assign xfer      = data_wr | data_rd;
  // byte bus completes a word on the high byte [R23] [R7]
  assign word_done = xfer & (bus_width_bit | byte_ptr);
  assign cmd_load  = cmd_wr & (cmd_data[7:5] == `TDPS_CMD_LOAD_PTR);

  // ------------------------------------------------------------
  // status and outputs
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_out
      logic cmp_match;
      logic cmp_en;
      if (gi < 2) begin : g_cmp
        // true while count equals alarm [R18]
        assign cmp_match = counter_value[gi*16 +: 16] == alarm_compare_value[gi];
        assign cmp_en    = global_config[`TDPS_GC_CMP1_BIT + gi];
      end else begin : g_nocmp
        assign cmp_match = 1'b0;
        assign cmp_en    = 1'b0;
      end
      tdps_out_logic u_out (
        .output_control_field (counter_config[gi][2:0]),
        .cmp_enable           (cmp_en),
        .terminal_count       (terminal_count[gi]),
        .cmp_match            (cmp_match),
        .out_level            (out_level[gi])
      );
      // tc reload source: reload or capture register [R16] [R21]
      assign reload_word[gi*16 +: 16] = alt_src[gi] ? capture_value[gi] : reload_value[gi];
      assign reload_from_capture[gi]  = alt_src[gi];
    end
  endgenerate
  // spare bits read as zero [R12]
  assign count_status = {2'b00, out_level, byte_ptr};

  // ------------------------------------------------------------
  // addressed register
  // ------------------------------------------------------------
  always_comb begin
    addressed = 16'h0000;
    if (group_ptr == `TDPS_GRP_CONTROL) begin
      if (element_ptr == `TDPS_CTL_ALARM1) begin
        addressed = alarm_compare_value[0];
      end else if (element_ptr == `TDPS_CTL_GLOBAL) begin
        addressed = global_config;
      end else if (element_ptr == `TDPS_CTL_ALARM2) begin
        addressed = alarm_compare_value[1];
      end else begin
        addressed = {8'h00, count_status}; // [R5]
      end
    end else if (group_ptr >= `TDPS_GRP_FIRST && group_ptr <= `TDPS_GRP_LAST) begin
      // codes 1..5 are counters 1..5 [R25] [R15]
      if (element_ptr == `TDPS_ELEM_MODE) begin
        addressed = counter_config[group_ptr - 3'h1];
      end else if (element_ptr == `TDPS_ELEM_RELOAD) begin
        addressed = reload_value[group_ptr - 3'h1];
      end else begin
        addressed = capture_value[group_ptr - 3'h1];
      end
    end
  end

  always_comb begin
    if (group_ptr == `TDPS_GRP_CONTROL) begin
      cycle = (element_ptr == `TDPS_ELEM_HOLDCYC) ? TDPS_CYC_STATUS : TDPS_CYC_CONTROL;
    end else begin
      cycle = (element_ptr == `TDPS_ELEM_HOLDCYC) ? TDPS_CYC_HOLD : TDPS_CYC_ELEMENT;
    end
  end

  // ------------------------------------------------------------
  // data pointer
  // ------------------------------------------------------------
  always_comb begin
    next_group_ptr   = group_ptr;
    next_element_ptr = element_ptr;
    next_byte_ptr    = bus_width_bit ? 1'b1 : byte_ptr; // [R23]
    if (cmd_load) begin
      next_group_ptr   = cmd_data[4:2];
      next_element_ptr = cmd_data[1:0];
      next_byte_ptr    = bus_width_bit;
    end else if (xfer) begin
      if (!bus_width_bit) begin
        next_byte_ptr = ~byte_ptr; // [R7]
      end
      if (word_done && !sequencing_disable_bit) begin // [R24]
        case (cycle)
          TDPS_CYC_ELEMENT: begin
            // no step to 11, wrap bumps group [R1] [R2]
            if (element_ptr == `TDPS_ELEM_CAPTURE) begin
              next_element_ptr = `TDPS_ELEM_MODE;
              next_group_ptr   = (group_ptr >= `TDPS_GRP_LAST) ? `TDPS_GRP_FIRST
                                                                : group_ptr + 3'h1;
            end else begin
              next_element_ptr = element_ptr + 2'h1;
            end
          end
          TDPS_CYC_HOLD: begin
            next_group_ptr = (group_ptr >= `TDPS_GRP_LAST) ? `TDPS_GRP_FIRST
                                                            : group_ptr + 3'h1; // [R3]
          end
          TDPS_CYC_CONTROL: begin
            next_element_ptr = (element_ptr == `TDPS_CTL_ALARM2) ? `TDPS_CTL_ALARM1
                                                                  : element_ptr + 2'h1; // [R4]
          end
          default: begin
            next_element_ptr = element_ptr; // [R5]
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // writes, global config and prefetch
  // ------------------------------------------------------------
  always_comb begin
    next_global_config = global_config;
    next_wr_word       = wr_word;
    next_alt_src       = alt_src ^ terminal_count; // alternate source per tc
    for (int k = 0; k < NUM_CNT; k++) begin
      if (counter_config[k][6] == 1'b0) begin
        next_alt_src[k] = 1'b0;
      end
    end
    if (data_wr && !bus_width_bit && !byte_ptr) begin
      next_wr_word = {wr_word[15:8], data_in[7:0]};
    end
    if (cmd_wr && (cmd_data[7:5] == `TDPS_CMD_SET_BIT || cmd_data[7:5] == `TDPS_CMD_CLR_BIT)
        && cmd_data[4:0] >= 5'd12 && cmd_data[4:0] <= 5'd14) begin
      next_global_config[cmd_data[3:0]] = (cmd_data[7:5] == `TDPS_CMD_SET_BIT); // [R20]
    end
    if (data_wr && word_done && group_ptr == `TDPS_GRP_CONTROL
        && element_ptr == `TDPS_CTL_GLOBAL) begin
      next_global_config = bus_width_bit ? data_in : {data_in[7:0], wr_word[7:0]}; // [R20]
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_CNT; k++) begin
      sw_capture[k] = cmd_wr && cmd_data[7:5] == `TDPS_CMD_CAPTURE
                      && cmd_data[4:0] == 5'(k + 1); // [R17]
    end
  end

  // refill the cycle after the pointer settles [R8] [R9]
  assign next_refill = xfer | cmd_load;
  always_comb begin
    next_prefetch = prefetch;
    if (refill) begin
      next_prefetch = addressed;
    end
  end

  // narrow reads put the pointed byte on the low lines [R23]
  always_comb begin
    if (ctrl_rd) begin
      rd_data = {8'h00, count_status}; // [R6]
    end else if (bus_width_bit) begin
      rd_data = prefetch; // [R8]
    end else begin
      rd_data = {8'h00, byte_ptr ? prefetch[15:8] : prefetch[7:0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      group_ptr     <= 3'h0;
      element_ptr   <= 2'h0;
      byte_ptr      <= 1'b0;
      prefetch      <= 16'h0000;
      refill        <= 1'b0;
      global_config <= `TDPS_GC_RESET;
      wr_word       <= 16'h0000;
      alt_src       <= '0;
    end else begin
      group_ptr     <= next_group_ptr;
      element_ptr   <= next_element_ptr;
      byte_ptr      <= next_byte_ptr;
      prefetch      <= next_prefetch;
      refill        <= next_refill;
      global_config <= next_global_config;
      wr_word       <= next_wr_word;
      alt_src       <= next_alt_src;
    end
  end

  // per-counter registers; hardware capture wins over host write
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_regs
      logic        hit;
      logic [15:0] wval;
      assign hit  = data_wr && word_done && group_ptr == 3'(gi + 1);
      assign wval = bus_width_bit ? data_in : {data_in[7:0], wr_word[7:0]};
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          reload_value[gi]   <= 16'h0000;
          capture_value[gi]  <= 16'h0000;
          counter_config[gi] <= 16'h0000;
        end else begin
          if (hit && element_ptr == `TDPS_ELEM_MODE) begin
            counter_config[gi] <= wval;
          end
          if (hit && element_ptr == `TDPS_ELEM_RELOAD) begin
            reload_value[gi] <= wval; // [R15]
          end
          if (hw_capture[gi] || sw_capture[gi]) begin
            capture_value[gi] <= counter_value[gi*16 +: 16]; // [R17]
          end else if (hit && element_ptr[1]) begin
            capture_value[gi] <= wval;
          end
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_alarm
      logic ahit;
      assign ahit = data_wr && word_done && group_ptr == `TDPS_GRP_CONTROL
                    && element_ptr == 2'(gi * 2);
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          alarm_compare_value[gi] <= 16'h0000;
        end else if (ahit) begin
          alarm_compare_value[gi] <= bus_width_bit ? data_in : {data_in[7:0], wr_word[7:0]};
        end
      end
    end
  endgenerate
endmodule // tdps_sequencer
`default_nettype wire

/* File: tdps_sequencer_props.sv */
// Purpose: concurrent checks on the timer data port sequencer ports
// Assumes: strobes are single-cycle pulses on sys_clk
// Notes:   bound to every tdps_sequencer instance
`timescale 1ns/10ps
`default_nettype none
module tdps_sequencer_props #(
  parameter int NUM_CNT = 5
) (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst,
  // host side
  input wire logic               cmd_wr,
  input wire logic [7:0]         cmd_data,
  input wire logic               data_wr,
  input wire logic               data_rd,
  input wire logic               ctrl_rd,
  input wire logic [15:0]        rd_data,
  // counter and pins
  input wire logic [NUM_CNT-1:0] terminal_count,
  input wire logic [NUM_CNT-1:0] sw_capture,
  input wire logic [NUM_CNT-1:0] out_level,
  input wire logic               freq_out_gate_bit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // quiet time since the last host access
  // ----------------------------------------
  logic [1:0] quiet;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) quiet <= 2'h0;
    else if (cmd_wr | data_wr | data_rd | ctrl_rd) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  chk_ctrl_status:
    assert property (ctrl_rd |-> rd_data[15:6] == 10'h000 && rd_data[5:1] == out_level)
    else $error("control port read did not show status");
  chk_gate_set:
    assert property (cmd_wr && cmd_data == 8'h2c |=> freq_out_gate_bit)
    else $error("gate bit not set by command");
  chk_gate_clear:
    assert property (cmd_wr && cmd_data == 8'h4c |=> !freq_out_gate_bit)
    else $error("gate bit not cleared by command");
  chk_gate_hold:
    assert property (!cmd_wr && !data_wr |=> $stable(freq_out_gate_bit))
    else $error("gate bit changed without cause");
  chk_swcap_pulse:
    assert property (cmd_wr && cmd_data[7:5] == 3'h3 && cmd_data[4:0] inside {[5'h1:5'h5]}
      |-> sw_capture == (NUM_CNT'(1) << (cmd_data[4:0] - 5'h1)))
    else $error("capture command hit the wrong counter");
  chk_swcap_idle:
    assert property (!(cmd_wr && cmd_data[7:5] == 3'h3) |-> sw_capture == '0)
    else $error("capture pulse without command");
  // hardware capture must not refresh the latch, hence stale reads
  chk_prefetch_quiet:
    assert property (quiet == 2'h3 && !ctrl_rd |-> $stable(rd_data))
    else $error("prefetch changed with no access");
  chk_out_quiet:
    assert property (quiet == 2'h3 && $stable(terminal_count)
      && $past(terminal_count) == $past(terminal_count, 2) |-> $stable(out_level[4:2]))
    else $error("output moved with no terminal count change");
  cover property (ctrl_rd);
  cover property (data_rd ##1 !data_rd);
  cover property (sw_capture != '0);
endmodule // tdps_sequencer_props
bind tdps_sequencer tdps_sequencer_props #(.NUM_CNT(NUM_CNT)) props_i (
  .sys_clk(sys_clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
  .data_wr(data_wr), .data_rd(data_rd), .ctrl_rd(ctrl_rd), .rd_data(rd_data),
  .terminal_count(terminal_count), .sw_capture(sw_capture), .out_level(out_level),
  .freq_out_gate_bit(freq_out_gate_bit));
`default_nettype wire

/* File: tdps_host_model.sv */
// Purpose: host bus model for the control and data ports
// Assumes: strobes launched by non-blocking assignment at sys_clk rise
// Notes:   released lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module tdps_host_model (
  // clock
  input  wire logic        sys_clk,
  // strobes
  output logic             cmd_wr,
  output logic [7:0]       cmd_data,
  output logic             data_wr,
  output logic             data_rd,
  output logic [15:0]      data_in,
  output logic             ctrl_rd,
  // answer
  input  wire logic [15:0] rd_data
);
  initial {cmd_wr, cmd_data, data_wr, data_rd, data_in, ctrl_rd} = '0;
  // latch refill takes two edges, so every access is followed by three
  task automatic idle();
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    cmd_data <= c;
    cmd_wr   <= 1'b1;
    @(posedge sys_clk);
    cmd_wr   <= 1'b0;
    cmd_data <= ~c;
    idle();
  endtask
  // pointer reloaded before every read after other commands
  task automatic ld_ptr(input logic [2:0] g, input logic [1:0] e);
    cmd({3'h0, g, e});
  endtask
  task automatic wr(input logic [15:0] d);
    data_in <= d;
    data_wr <= 1'b1;
    @(posedge sys_clk);
    data_wr <= 1'b0;
    data_in <= ~d;
    idle();
  endtask
  task automatic rd(output logic [15:0] d);
    data_rd <= 1'b1;
    @(posedge sys_clk);
    d = rd_data;
    data_rd <= 1'b0;
    idle();
  endtask
  task automatic status(output logic [15:0] s);
    ctrl_rd <= 1'b1;
    @(posedge sys_clk);
    s = {8'h00, rd_data[7:0]};
    ctrl_rd <= 1'b0;
    idle();
  endtask
endmodule // tdps_host_model
`default_nettype wire

/* File: timer_data_port_sequencer_tb.sv */
// Purpose: self-checking bench for the timer data port sequencer
// Assumes: host model issues one access at a time
// Notes:   pointer and register contents are modelled in the bench
`timescale 1ns/10ps
`default_nettype none
module timer_data_port_sequencer_tb;
  logic        sys_clk, rst, cmd_wr, data_wr, data_rd, ctrl_rd, freq_out_gate_bit;
  logic [7:0]  cmd_data;
  logic [15:0] data_in, rd_data, v, s;
  logic [79:0] counter_value, reload_word;
  logic [4:0]  terminal_count, hw_capture, reload_from_capture, sw_capture, out_level, tcv;
  logic [15:0] mem [8][4];
  int          errors, compares, cycles, seed, grp, elm;
  bit          seqdis, wide;
  tdps_host_model host_i (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .data_wr(data_wr), .data_rd(data_rd), .data_in(data_in), .ctrl_rd(ctrl_rd),
    .rd_data(rd_data));
  tdps_sequencer tdps_sequencer_i (.sys_clk(sys_clk), .rst(rst), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .data_wr(data_wr), .data_rd(data_rd), .data_in(data_in),
    .ctrl_rd(ctrl_rd), .rd_data(rd_data), .counter_value(counter_value),
    .terminal_count(terminal_count), .reload_from_capture(reload_from_capture),
    .reload_word(reload_word), .sw_capture(sw_capture), .hw_capture(hw_capture),
    .out_level(out_level), .freq_out_gate_bit(freq_out_gate_bit));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // pointer model
  // ----------------------------------------
  function automatic void advance();
    if (seqdis) return;
    if (grp == 7) begin
      if (elm != 3) elm = (elm == 2) ? 0 : elm + 1;
    end else if (elm == 3) grp = (grp == 5) ? 1 : grp + 1;
    else if (elm == 2) begin
      elm = 0;
      grp = (grp == 5) ? 1 : grp + 1;
    end else elm++;
  endfunction
  // hold cycle reaches the capture register of the group
  function automatic int slot();
    return (grp != 7 && elm == 3) ? 2 : elm;
  endfunction
  task automatic ld(input int g, input int e);
    host_i.ld_ptr(3'(g), 2'(e));
    grp = g;
    elm = e;
  endtask
  task automatic wr16(input logic [15:0] d);
    if (wide) host_i.wr(d);
    else begin
      host_i.wr({8'h00, d[7:0]});
      host_i.wr({8'h00, d[15:8]});
    end
    mem[grp][slot()] = d;
    advance();
  endtask
  task automatic rd16();
    logic [15:0] a, b;
    host_i.rd(a);
    if (wide) check(a, mem[grp][slot()]);
    else begin
      host_i.rd(b);
      check({b[7:0], a[7:0]}, mem[grp][slot()]);
    end
    advance();
  endtask
  initial begin
    {errors, compares, cycles, grp, elm, seqdis, wide} = '0;
    seed = 70;
    rst = 1'b1;
    {counter_value, terminal_count, hw_capture} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    counter_value <= 80'({$random(seed), $random(seed), $random(seed)});
    @(posedge sys_clk);
    host_i.status(s);
    check(s, 16'h0000);
    ld(1, 0);
    for (int i = 0; i < 15; i++) begin
      v = 16'($random(seed));
      // mode words keep output control at 000 so outputs stay low
      if (elm == 0) v = v & 16'hff00;
      wr16(v);
    end
    ld(1, 0);
    repeat (16) rd16();
    ld(1, 3);
    repeat (6) rd16();
    ld(7, 0);
    wr16(16'($random(seed)));
    wr16(16'h0000);
    wr16(16'($random(seed)));
    ld(7, 0);
    repeat (3) rd16();
    host_i.cmd(8'h63);
    mem[3][2] = counter_value[47:32];
    ld(3, 2);
    rd16();
    ld(4, 2);
    hw_capture <= 5'h08;
    @(posedge sys_clk);
    hw_capture <= 5'h00;
    mem[4][2] = counter_value[63:48];
    ld(4, 2);
    rd16();
    host_i.cmd(8'h2c);
    check({15'h0000, freq_out_gate_bit}, 16'h0001);
    host_i.cmd(8'h4c);
    check({15'h0000, freq_out_gate_bit}, 16'h0000);
    host_i.cmd(8'h2e);
    seqdis = 1'b1;
    ld(2, 1);
    wr16(16'($random(seed)));
    rd16();
    host_i.cmd(8'h4e);
    seqdis = 1'b0;
    host_i.cmd(8'h2d);
    wide = 1'b1;
    host_i.status(s);
    check(s, 16'h0001);
    mem[7][3] = 16'h0001;
    ld(7, 3);
    repeat (2) rd16();
    ld(3, 0);
    wr16(16'h0004);
    host_i.status(s);
    check(s, 16'h0009);
    check({11'h000, reload_from_capture}, 16'h0000);
    // mode word with alternate reload source, reload zeroed to accumulate
    ld(5, 0);
    wr16(16'h0040);
    wr16(16'h0000);
    check(reload_word[79:64], 16'h0000);
    terminal_count <= 5'h10;
    @(posedge sys_clk);
    terminal_count <= 5'h00;
    @(posedge sys_clk);
    check({11'h000, reload_from_capture}, 16'h0010);
    check(reload_word[79:64], mem[5][2]);
    terminal_count <= 5'h04;
    @(posedge sys_clk);
    host_i.status(s);
    check(s, 16'h0001);
    tcv = 5'($random(seed));
    terminal_count <= tcv;
    @(posedge sys_clk);
    host_i.status(s);
    check(s, {10'h000, tcv ^ 5'h04, 1'b1});
    // comparator 1 on a grounded output shows active low
    ld(7, 1);
    wr16(16'h2004);
    host_i.status(s);
    check(s, {10'h000, tcv[4:1] ^ 4'h2, counter_value[15:0] != mem[7][0], 1'b1});
    ld(7, 0);
    wr16(counter_value[15:0]);
    host_i.status(s);
    check(s, {10'h000, tcv[4:1] ^ 4'h2, 2'b01});
    report_and_stop();
  end
endmodule // timer_data_port_sequencer_tb
`default_nettype wire
